// >>> hdl/usu_pkg.sv
// Package: constants and types of the USB serial bridge UART core
package usu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_BAUD = 8'h00;
  localparam logic [7:0] OFF_LINE = 8'h04;
  localparam logic [7:0] OFF_TOUT = 8'h08;
  localparam logic [7:0] OFF_TXD = 8'h0c;
  localparam logic [7:0] OFF_RXD = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_NADDR = 8'h18;
  localparam logic [7:0] OFF_NDATA = 8'h1c;
  localparam logic [7:0] OFF_ID = 8'h20;
  localparam logic [7:0] OFF_MODEM = 8'h24;
  // Divisor fields: integer 13:0 (0 means 16384), eighths 16:14
  localparam int BAUD_FRAC_LSB = 14;
  localparam logic [16:0] BAUD_RST = 17'h10138;
  // Line control fields
  localparam int LINE_SEV_BIT = 2;
  localparam int LINE_TWO_BIT = 3;
  localparam int LINE_FLOW_LSB = 4;
  localparam int LINE_RTS_BIT = 6;
  localparam int LINE_DTR_BIT = 7;
  localparam logic [7:0] LINE_RST = 8'hc0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_RTS = 2'h1;
  localparam logic [1:0] FLOW_DTR = 2'h2;
  localparam logic [1:0] FLOW_XON = 2'h3;
  // Status sticky bits, write one to clear
  localparam int STAT_FLUSH_BIT = 24;
  localparam int STAT_FERR_BIT = 26;
  localparam int STAT_PERR_BIT = 27;
  localparam int STAT_OVR_BIT = 28;
  // Config word 0 of the store: inversion mask 7:0, wake enable 8
  localparam int CFG_WAKE_BIT = 8;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam int INV_TXD = 0;
  localparam int INV_RXD = 1;
  localparam int INV_RTS = 2;
  localparam int INV_CTS = 3;
  localparam int INV_DTR = 4;
  localparam int INV_DSR = 5;
  localparam int INV_DCD = 6;
  localparam int INV_RI = 7;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int REF_HZ = 3_000_000;
  localparam int CLK_NS = 25;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic [7:0] TOUT_DEF_MS = 8'h10;
  localparam int RX_HEAD = 32;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // Serial engine states
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} usu_ser_t;
endpackage

// >>> hdl/usu_baud_gen.sv
// Fractional bit-time tick generator counting eighths of the reference
`timescale 1ns/10ps
`default_nettype none
module usu_baud_gen #(
  parameter int ACC_W = 18
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic ref_tick,
  input wire logic restart,
  input wire logic [17:0] preload,
  input wire logic [17:0] div8,
  // Bit time
  output logic tick
);
  if (ACC_W != 18) begin : g_bad
    $error("usu_baud_gen: ACC_W must be 18");
  end

  logic [17:0] acc_q;
  wire [17:0] acc_nxt = acc_q + 18'h8;
  wire wrap = acc_nxt >= div8;

  // Each reference tick adds eight; the divisor is in eighths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 18'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart) begin
        acc_q <= preload;
      end else if (ref_tick && wrap) begin
        acc_q <= acc_nxt - div8;
        tick <= 1'b1;
      end else if (ref_tick) begin
        acc_q <= acc_nxt;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/usu_core.sv
// UART core: APB registers, queues, framer, divider, timeout, store
//
// The address map and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module usu_core #(
  parameter int MS_CYC = usu_pkg::MS_CYC,
  parameter int TXQ_DEPTH = 128,
  parameter int RXQ_DEPTH = 256,
  parameter int NVM_WORDS = 32,
  parameter logic [63:0] SERIAL_NUM = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [31:0] CHIP_ID = 32'h1357_9bdf // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic dcd_i,
  input wire logic ri_i,
  output logic txd_o,
  output logic rts_o,
  output logic dtr_o,
  // USB engine side
  input wire logic suspend_i,
  output logic resume_o,
  output logic flush_o
);
  localparam int TA = $clog2(TXQ_DEPTH);
  localparam int RA = $clog2(RXQ_DEPTH);
  localparam int NA = $clog2(NVM_WORDS);
  localparam int MSW = $clog2(MS_CYC + 1);

  if (TXQ_DEPTH != (1 << TA) || RXQ_DEPTH != (1 << RA) || TA > 7 || RA > 8
      || RXQ_DEPTH <= usu_pkg::RX_HEAD || NVM_WORDS < 8 || MS_CYC < 2) begin : g_bad
    $error("usu_core: unsupported parameter values");
  end

  // APB decode
  wire apb_acc = psel & penable;
  wire apb_done = apb_acc & pready;
  wire wr = apb_done & pwrite;
  wire hit_baud = paddr == usu_pkg::OFF_BAUD;
  wire hit_line = paddr == usu_pkg::OFF_LINE;
  wire hit_tout = paddr == usu_pkg::OFF_TOUT;
  wire hit_txd = paddr == usu_pkg::OFF_TXD;
  wire hit_rxd = paddr == usu_pkg::OFF_RXD;
  wire hit_stat = paddr == usu_pkg::OFF_STAT;
  wire hit_na = paddr == usu_pkg::OFF_NADDR;
  wire hit_nd = paddr == usu_pkg::OFF_NDATA;
  wire hit_id = paddr == usu_pkg::OFF_ID;
  wire hit_mdm = paddr == usu_pkg::OFF_MODEM;
  wire hit_any = hit_baud | hit_line | hit_tout | hit_txd | hit_rxd | hit_stat
                 | hit_na | hit_nd | hit_id | hit_mdm;

  logic [16:0] baud_q;
  logic [7:0] line_q;
  logic [7:0] tout_q;
  logic [NA-1:0] naddr_q;
  logic flush_q, ferr_q, perr_q, ovr_q, xoff_q;

  // Store: word 0 config, words 1-4 serial number, the rest user area
  logic [15:0] nvm_q [NVM_WORDS];
  wire nvm_we = wr & hit_nd;
  wire [15:0] nvm_rd = nvm_q[naddr_q];
  for (genvar i = 0; i < NVM_WORDS; i++) begin : g_nvm
    localparam logic [63:0] SH = SERIAL_NUM >> (16 * ((i >= 1 && i <= 4) ? i - 1 : 0));
    localparam logic [15:0] RV = (i == 0) ? usu_pkg::CFG_RST :
                                 (i <= 4) ? SH[15:0] : 16'h0;
    // Written in place with no programming phase
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        nvm_q[i] <= RV;
      end else if (ce && nvm_we && int'(naddr_q) == i) begin
        nvm_q[i] <= pwdata[15:0];
      end
    end
  end
  wire [7:0] inv = nvm_q[0][7:0];
  wire wake_en = nvm_q[0][usu_pkg::CFG_WAKE_BIT];

  // Pins to logical levels through the inversion mask
  wire rxd_l = rxd_i ^ inv[usu_pkg::INV_RXD];
  wire cts_act = ~(cts_i ^ inv[usu_pkg::INV_CTS]);
  wire dsr_act = ~(dsr_i ^ inv[usu_pkg::INV_DSR]);
  wire dcd_act = ~(dcd_i ^ inv[usu_pkg::INV_DCD]);
  wire ri_act = ~(ri_i ^ inv[usu_pkg::INV_RI]);

  // Divisor in eighths; integer 1 drops the fraction
  wire [13:0] bint = baud_q[13:0];
  wire [2:0] bfrac = baud_q[16:usu_pkg::BAUD_FRAC_LSB];
  wire [14:0] bn = (bint == 14'h0) ? 15'h4000 : {1'b0, bint};
  wire [17:0] div8 = (bn == 15'h1) ? 18'h8 : {bn, bfrac};

  // 3 MHz reference from pclk by phase accumulation
  logic [25:0] ref_q;
  logic ref_tick;
  wire [26:0] ref_nxt = {1'b0, ref_q} + 27'(usu_pkg::REF_HZ);
  wire ref_wrap = ref_nxt >= 27'(usu_pkg::CLK_HZ);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 26'h0;
      ref_tick <= 1'b0;
    end else if (ce) begin
      ref_q <= ref_wrap ? 26'(ref_nxt - 27'(usu_pkg::CLK_HZ)) : ref_nxt[25:0];
      ref_tick <= ref_wrap;
    end
  end

  // Line settings
  wire [1:0] par = line_q[1:0];
  wire seven = line_q[usu_pkg::LINE_SEV_BIT];
  wire two = line_q[usu_pkg::LINE_TWO_BIT];
  wire [1:0] flow = line_q[usu_pkg::LINE_FLOW_LSB +: 2];
  wire par_en = par != usu_pkg::PAR_NONE;
  wire odd = par == usu_pkg::PAR_ODD;
  wire [2:0] last_bit = seven ? 3'h6 : 3'h7;

  // Queues
  logic [7:0] tx_mem [TXQ_DEPTH];
  logic [7:0] rx_mem [RXQ_DEPTH];
  logic [TA:0] tx_wp, tx_rp;
  logic [RA:0] rx_wp, rx_rp;
  wire [TA:0] tx_cnt = tx_wp - tx_rp;
  wire [RA:0] rx_cnt = rx_wp - rx_rp;
  wire tx_full = tx_cnt == (TA+1)'(TXQ_DEPTH);
  wire tx_empty = tx_cnt == '0;
  wire rx_full = rx_cnt == (RA+1)'(RXQ_DEPTH);
  wire rx_empty = rx_cnt == '0;
  wire rx_room = rx_cnt <= (RA+1)'(RXQ_DEPTH - usu_pkg::RX_HEAD);

  // Flow control gating and handshake drive
  wire tx_ok = (flow == usu_pkg::FLOW_RTS) ? cts_act :
               (flow == usu_pkg::FLOW_DTR) ? dsr_act :
               (flow == usu_pkg::FLOW_XON) ? ~xoff_q : 1'b1;
  wire rts_act = (flow == usu_pkg::FLOW_RTS) ? rx_room : line_q[usu_pkg::LINE_RTS_BIT];
  wire dtr_act = (flow == usu_pkg::FLOW_DTR) ? rx_room : line_q[usu_pkg::LINE_DTR_BIT];

  // Transmit framer
  usu_pkg::usu_ser_t tx_st_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_n_q;
  logic tx_bit_q, tx_tick;
  wire [7:0] tx_head = tx_mem[tx_rp[TA-1:0]];
  wire [7:0] tx_word = seven ? {1'b0, tx_head[6:0]} : tx_head;
  wire tx_go = (tx_st_q == usu_pkg::S_IDLE) & ~tx_empty & tx_ok;
  logic tx_par_q;
  usu_baud_gen u_tx_baud (
    .pclk(pclk), .presetn(presetn), .ce(ce), .ref_tick(ref_tick),
    .restart(tx_go), .preload(18'h0), .div8(div8), .tick(tx_tick)
  );
  // Start low, data LSB first, parity, high stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= usu_pkg::S_IDLE;
      tx_sh_q <= 8'h0;
      tx_n_q <= 3'h0;
      tx_bit_q <= 1'b1;
      tx_par_q <= 1'b0;
    end else if (ce) begin
      case (tx_st_q)
        usu_pkg::S_IDLE: if (tx_go) begin
          tx_sh_q <= tx_word;
          tx_par_q <= ^tx_word ^ odd;
          tx_bit_q <= 1'b0;
          tx_st_q <= usu_pkg::S_START;
        end
        usu_pkg::S_START: if (tx_tick) begin
          tx_bit_q <= tx_sh_q[0];
          tx_sh_q <= tx_sh_q >> 1;
          tx_n_q <= last_bit;
          tx_st_q <= usu_pkg::S_DATA;
        end
        usu_pkg::S_DATA: if (tx_tick) begin
          // Count runs from the last bit index down; zero means data is done
          if (tx_n_q != 3'h0) begin
            tx_bit_q <= tx_sh_q[0];
            tx_sh_q <= tx_sh_q >> 1;
            tx_n_q <= tx_n_q - 3'h1;
          end else begin
            tx_bit_q <= par_en ? tx_par_q : 1'b1;
            tx_n_q <= {2'h0, two};
            tx_st_q <= par_en ? usu_pkg::S_PAR : usu_pkg::S_STOP;
          end
        end
        usu_pkg::S_PAR: if (tx_tick) begin
          tx_bit_q <= 1'b1;
          tx_st_q <= usu_pkg::S_STOP;
        end
        usu_pkg::S_STOP: if (tx_tick) begin
          if (tx_n_q == 3'h0) begin
            tx_st_q <= usu_pkg::S_IDLE;
          end else begin
            tx_n_q <= tx_n_q - 3'h1;
          end
        end
        default: tx_st_q <= usu_pkg::S_IDLE;
      endcase
    end
  end

  // Receive framer: restart half a bit in so ticks land mid-bit
  usu_pkg::usu_ser_t rx_st_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_n_q;
  logic rx_prev_q, rx_pbit_q, rx_tick;
  wire rx_fall = (rx_st_q == usu_pkg::S_IDLE) & rx_prev_q & ~rxd_l;
  usu_baud_gen u_rx_baud (
    .pclk(pclk), .presetn(presetn), .ce(ce), .ref_tick(ref_tick),
    .restart(rx_fall), .preload({1'b0, div8[17:1]}), .div8(div8), .tick(rx_tick)
  );
  wire [7:0] rx_byte = seven ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;
  wire rx_fin = (rx_st_q == usu_pkg::S_STOP) & rx_tick;
  wire rx_good = rx_fin & rxd_l;
  wire rx_perr = par_en & ((^rx_byte ^ rx_pbit_q) != odd);
  wire is_xon = (flow == usu_pkg::FLOW_XON) & (rx_byte == usu_pkg::XON_CHAR);
  wire is_xoff = (flow == usu_pkg::FLOW_XON) & (rx_byte == usu_pkg::XOFF_CHAR);
  wire rx_keep = rx_good & ~is_xon & ~is_xoff;
  wire rx_push = rx_keep & ~rx_full;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= usu_pkg::S_IDLE;
      rx_sh_q <= 8'h0;
      rx_n_q <= 3'h0;
      rx_prev_q <= 1'b1;
      rx_pbit_q <= 1'b0;
    end else if (ce) begin
      rx_prev_q <= rxd_l;
      case (rx_st_q)
        usu_pkg::S_IDLE: if (rx_fall) rx_st_q <= usu_pkg::S_START;
        usu_pkg::S_START: if (rx_tick) begin
          rx_n_q <= last_bit;
          rx_st_q <= rxd_l ? usu_pkg::S_IDLE : usu_pkg::S_DATA;
        end
        usu_pkg::S_DATA: if (rx_tick) begin
          rx_sh_q <= {rxd_l, rx_sh_q[7:1]};
          rx_n_q <= rx_n_q - 3'h1;
          if (rx_n_q == 3'h0) rx_st_q <= par_en ? usu_pkg::S_PAR : usu_pkg::S_STOP;
        end
        usu_pkg::S_PAR: if (rx_tick) begin
          rx_pbit_q <= rxd_l;
          rx_st_q <= usu_pkg::S_STOP;
        end
        usu_pkg::S_STOP: if (rx_tick) rx_st_q <= usu_pkg::S_IDLE;
        default: rx_st_q <= usu_pkg::S_IDLE;
      endcase
    end
  end

  // Queue pointers; APB pushes and pops commit only at the APB completion edge
  wire tx_push = wr & hit_txd & ~tx_full;
  wire rx_pop = apb_done & ~pwrite & hit_rxd & ~rx_empty;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
    end else if (ce) begin
      tx_wp <= tx_wp + (TA+1)'(tx_push);
      tx_rp <= tx_rp + (TA+1)'(tx_go);
      rx_wp <= rx_wp + (RA+1)'(rx_push);
      rx_rp <= rx_rp + (RA+1)'(rx_pop);
    end
  end
  // Queue storage needs no reset
  always_ff @(posedge pclk) begin
    if (ce && tx_push) tx_mem[tx_wp[TA-1:0]] <= pwdata[7:0];
    if (ce && rx_push) rx_mem[rx_wp[RA-1:0]] <= rx_byte;
  end

  // Flush timer: millisecond prescaler and count, restarted per queued character
  logic [MSW-1:0] ms_q;
  logic [7:0] to_q;
  wire ms_tick = ms_q == MSW'(MS_CYC - 1);
  wire [7:0] tout_eff = (tout_q == 8'h0) ? 8'h1 : tout_q;
  wire to_exp = ~rx_push & ~rx_empty & ms_tick & ({1'b0, to_q} + 9'h1 >= {1'b0, tout_eff});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= '0;
      to_q <= 8'h0;
    end else if (ce) begin
      if (rx_push || rx_empty) begin
        ms_q <= '0;
        to_q <= 8'h0;
      end else if (ms_tick) begin
        ms_q <= '0;
        to_q <= to_exp ? 8'h0 : to_q + 8'h1;
      end else begin
        ms_q <= ms_q + MSW'(1);
      end
    end
  end

  // Control registers and sticky flags; a set wins over a clear
  wire w_stat = wr & hit_stat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_q <= usu_pkg::BAUD_RST;
      line_q <= usu_pkg::LINE_RST;
      tout_q <= usu_pkg::TOUT_DEF_MS;
      naddr_q <= '0;
      flush_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      ovr_q <= 1'b0;
      xoff_q <= 1'b0;
    end else if (ce) begin
      if (wr && hit_baud) baud_q <= pwdata[16:0];
      if (wr && hit_line) line_q <= pwdata[7:0];
      if (wr && hit_tout) tout_q <= pwdata[7:0];
      if (wr && hit_na) naddr_q <= pwdata[NA-1:0];
      flush_q <= to_exp | (flush_q & ~(w_stat & pwdata[usu_pkg::STAT_FLUSH_BIT]));
      ferr_q <= (rx_fin & ~rxd_l) | (ferr_q & ~(w_stat & pwdata[usu_pkg::STAT_FERR_BIT]));
      perr_q <= (rx_good & rx_perr) | (perr_q & ~(w_stat & pwdata[usu_pkg::STAT_PERR_BIT]));
      ovr_q <= (rx_keep & rx_full) | (ovr_q & ~(w_stat & pwdata[usu_pkg::STAT_OVR_BIT]));
      if (flow != usu_pkg::FLOW_XON) xoff_q <= 1'b0;
      else if (rx_good && is_xoff) xoff_q <= 1'b1;
      else if (rx_good && is_xon) xoff_q <= 1'b0;
    end
  end

  // Read data selection
  wire [31:0] stat_w = {3'h0, ovr_q, perr_q, ferr_q, xoff_q, flush_q,
                        8'(tx_cnt), 7'h0, 9'(rx_cnt)};
  wire [31:0] rd_mux = hit_baud ? {15'h0, baud_q} :
                       hit_line ? {24'h0, line_q} :
                       hit_tout ? {24'h0, tout_q} :
                       hit_txd ? {24'h0, 8'(tx_cnt)} :
                       hit_rxd ? {23'h0, ~rx_empty, rx_mem[rx_rp[RA-1:0]]} :
                       hit_stat ? stat_w :
                       hit_na ? 32'(naddr_q) :
                       hit_nd ? {16'h0, nvm_rd} :
                       hit_id ? CHIP_ID :
                       hit_mdm ? {28'h0, ri_act, dcd_act, dsr_act, cts_act} : 32'h0;

  // APB answer one cycle into the access phase; outputs and pins registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      txd_o <= 1'b1;
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
      resume_o <= 1'b0;
      flush_o <= 1'b0;
    end else if (ce) begin
      pready <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~hit_any;
      if (apb_acc && !pready) prdata <= pwrite ? 32'h0 : rd_mux;
      txd_o <= tx_bit_q ^ inv[usu_pkg::INV_TXD];
      rts_o <= ~rts_act ^ inv[usu_pkg::INV_RTS];
      dtr_o <= ~dtr_act ^ inv[usu_pkg::INV_DTR];
      resume_o <= wake_en & suspend_i & ri_act;
      flush_o <= to_exp;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  chk_div_one: assert property (bint == 14'h1 |-> div8 == 18'h8)
    else $error("Integer part one kept a fraction");
  chk_div_floor: assert property (div8 == 18'h8 || div8 >= 18'h10)
    else $error("Divisor fell between one and two");
  chk_frac_step: assert property (bint != 14'h1 |-> div8[2:0] == bfrac)
    else $error("Fraction eighths lost");
  chk_flush_data: assert property (flush_o |-> $past(rx_cnt) != '0)
    else $error("Flush with empty receive queue");
  chk_tx_start: assert property (tx_go |=> !tx_bit_q ##1 txd_o == inv[0])
    else $error("Start bit not low");
  chk_tx_stop: assert property (tx_st_q == usu_pkg::S_STOP |-> tx_bit_q)
    else $error("Stop bit not high");
  chk_cts_hold: assert property (tx_st_q == usu_pkg::S_IDLE && flow ==
    usu_pkg::FLOW_RTS && !cts_act |=> tx_st_q == usu_pkg::S_IDLE)
    else $error("Sent while clear-to-send idle");
  chk_wake_ring: assert property (wake_en && suspend_i && ri_act |=> resume_o)
    else $error("Ring did not resume host");
  chk_id_read: assert property (apb_acc && !pready && !pwrite && hit_id
    |=> prdata == CHIP_ID)
    else $error("Identifier read wrong");
  chk_nvm_write: assert property (nvm_we |=> nvm_rd == $past(pwdata[15:0]))
    else $error("Store word not written");
  chk_txq_cap: assert property (32'(tx_cnt) <= TXQ_DEPTH)
    else $error("Transmit queue over capacity");
  cov_flush: cover property (flush_o);
  cov_resume: cover property (resume_o);
  cov_rx_push: cover property (rx_push);
  cov_tx_done: cover property (tx_st_q == usu_pkg::S_STOP && tx_tick);
endmodule
`default_nettype wire

// >>> sim/usu_peer.sv
// RS232 peripheral model: frames characters onto the receive pin, captures the transmit pin
`timescale 1ns/10ps
`default_nettype none
module usu_peer (
  // Clock
  input wire logic pclk,
  // Serial lines seen from the peripheral
  input wire logic txd_i,
  output logic rxd_o
);
  // Mark level between characters, as an idle line rests
  initial rxd_o = 1'b1;
  // One 8N1 character, bc clock cycles to a bit
  task automatic send_byte(input int bc, input logic [7:0] d);
    @(posedge pclk);
    rxd_o <= 1'b0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= d[i];
      repeat (bc) @(posedge pclk);
    end
    rxd_o <= 1'b1;
    repeat (bc) @(posedge pclk);
  endtask
  // Capture one character at mid-bit; b[8] is the stop level, t0 the start edge
  task automatic get_byte(input int bc, output logic [8:0] b, output time t0);
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    t0 = $time;
    repeat (bc / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bc) @(posedge pclk);
      b[i] = txd_i;
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/usb_serial_uart_core_test.sv
// Self-checking bench of the UART core: registers, store, frames, timeout, wake
`timescale 1ns/10ps
`default_nettype none
module usb_serial_uart_core_test;
  localparam logic [63:0] SN = 64'h0fed_cba9_8765_4321; // Arbitrary value
  localparam logic [31:0] ID = 32'h2468_ace0; // Arbitrary value
  logic pclk = 1'b0;
  logic presetn, ce, psel, penable, pwrite, cts_i, dsr_i, dcd_i, ri_i, suspend_i;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, txd_o, rts_o, dtr_o, resume_o, flush_o;
  wire logic rxd_i;
  int n_mismatch = 0;
  int comparisons = 0;
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  usu_core #(.MS_CYC(50), .SERIAL_NUM(SN), .CHIP_ID(ID)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_i(rxd_i), .cts_i(cts_i), .dsr_i(dsr_i), .dcd_i(dcd_i),
    .ri_i(ri_i), .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o), .suspend_i(suspend_i),
    .resume_o(resume_o), .flush_o(flush_o));
  usu_peer u_peer (.pclk(pclk), .txd_i(txd_o), .rxd_o(rxd_i));
  // Comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  // APB transfer; the access phase is expected to last exactly two cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_near(n, 2, 0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk32(rd, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs some 12000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    logic [8:0] b;
    time t0, t1;
    int n;
    {presetn, psel, penable, pwrite, suspend_i} = 5'h0;
    {ce, cts_i, dsr_i, dcd_i, ri_i} = 5'h1f;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(usu_pkg::OFF_BAUD, {15'h0, usu_pkg::BAUD_RST});
    chk32({30'h0, rts_o, dtr_o}, 32'h0);
    wr(usu_pkg::OFF_ID, 32'h0);
    rdchk(usu_pkg::OFF_ID, ID);
    for (int i = 0; i < 4; i++) begin
      wr(usu_pkg::OFF_NADDR, 32'(i + 1));
      rdchk(usu_pkg::OFF_NDATA, {16'h0, SN[16 * i +: 16]});
    end
    wr(usu_pkg::OFF_NADDR, 32'h5);
    wr(usu_pkg::OFF_NDATA, 32'h0000_beef);
    rdchk(usu_pkg::OFF_NDATA, 32'h0000_beef);
    apb(1'b0, 8'h3c, 32'h0, rd, err);
    chk32({31'h0, err}, 32'h1);
    $display("test registers done");
    // Config word: pin inversion, then ring wake with and without enable
    wr(usu_pkg::OFF_NADDR, 32'h0);
    wr(usu_pkg::OFF_NDATA, 32'h1 << usu_pkg::INV_TXD);
    repeat (4) @(posedge pclk);
    chk32({31'h0, txd_o}, 32'h0);
    wr(usu_pkg::OFF_NDATA, 32'h1 << usu_pkg::CFG_WAKE_BIT);
    suspend_i <= 1'b1;
    ri_i <= 1'b0;
    repeat (4) @(posedge pclk);
    chk32({30'h0, resume_o, txd_o}, 32'h3);
    ri_i <= 1'b1;
    repeat (4) @(posedge pclk);
    chk32({30'h0, resume_o, txd_o}, 32'h1);
    wr(usu_pkg::OFF_NDATA, 32'h0);
    ri_i <= 1'b0;
    repeat (4) @(posedge pclk);
    chk32({31'h0, resume_o}, 32'h0);
    ri_i <= 1'b1;
    suspend_i <= 1'b0;
    $display("test inversion and wake done");
    // Every eighth step on integer 3; back-to-back characters give the frame span
    for (int x = 0; x < 8; x++) begin
      wr(usu_pkg::OFF_BAUD, 32'((x << 14) | 3));
      wr(usu_pkg::OFF_TXD, 32'h5a);
      fork
        u_peer.get_byte((24 + x) * 5 / 3, b, t0);
        wr(usu_pkg::OFF_TXD, 32'(x));
      join
      chk32({23'h0, b}, 32'h15a);
      u_peer.get_byte((24 + x) * 5 / 3, b, t1);
      chk32({23'h0, b}, 32'h100 | 32'(x));
      chk_near(int'((t1 - t0) / 25), (24 + x) * 50 / 3 + 2, 16);
      repeat ((24 + x) * 5 / 3) @(posedge pclk);
    end
    $display("test divisor and framing done");
    // Receive timeout at its default, then at 2 ms; no flush once empty
    wr(usu_pkg::OFF_BAUD, 32'h3);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        wr(usu_pkg::OFF_TOUT, 32'h2);
      end
      u_peer.send_byte(40, 8'h3c + 8'(k));
      n = 0;
      while (flush_o !== 1'b1 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      chk_near(n, (k == 1 ? 2 : 16) * 50 - 10, 15);
      rdchk(usu_pkg::OFF_STAT, 32'h0100_0001);
      rdchk(usu_pkg::OFF_RXD, 32'h13c + 32'(k));
      wr(usu_pkg::OFF_STAT, 32'h0100_0000);
      n = 0;
      repeat (900) begin
        @(posedge pclk);
        if (flush_o === 1'b1) n++;
      end
      chk_near(n, 0, 0);
    end
    $display("test receive timeout done");
    // Clear-to-send gating, then a seven-bit odd-parity two-stop frame
    wr(usu_pkg::OFF_LINE, 32'h1e);
    wr(usu_pkg::OFF_TXD, 32'h5a);
    repeat (100) @(posedge pclk);
    chk32({29'h0, rts_o, dtr_o, txd_o}, 32'h3);
    rdchk(usu_pkg::OFF_STAT, 32'h0001_0000);
    cts_i <= 1'b0;
    dcd_i <= 1'b0;
    u_peer.get_byte(40, b, t0);
    chk32({23'h0, b}, 32'h1da);
    rdchk(usu_pkg::OFF_MODEM, 32'h5);
    $display("test flow and frame options done");
    report_and_stop();
  end
endmodule
`default_nettype wire
